//--- design/ptrh_core.sv
/*
  ptrh_core: apb-visible control of positioning table rewrites. holds
  the buffer control area, one staged record buffer, the standard and
  extended table stores as flip-flops, recalculation and status.
  assumes: apb master on pclk, a motion engine that reads tables from
  act_table_o onward and waits for ext_ready_o.
*/
`timescale 1ns/100ps
// Contract
// RQ1: host writes axis, first table, count first
// RQ2: records are fourteen 16-bit words
// RQ3: host fills record buffer before requesting
// RQ4: host selects read or write beforehand
// RQ5: request flag starts selected read/write
// RQ6: host writes recalculation span first
// RQ7: host holds recalc request until done
// RQ8: host clears recalc count afterwards
// RQ9: standard region tables 1 to 1000
// RQ10: extended region tables 10001 to 10100
// RQ11: standard writes active only after recalc
// RQ12: extended writes usable without host recalc
// RQ13: extended start recalculates internally, adds delay
// RQ14: chained extended start delay grows per table
// RQ15: usage setting 0 disables, 1 enables extended
// RQ16: axis 1-64 real, 65-96 virtual, else error
// RQ17: bad number or count flags error, ignored
// RQ18: done flags for transfer and recalculation
module ptrh_core #(
  parameter int unsigned STD_DEPTH = ptrh_pkg::STD_TABLES,
  parameter int unsigned EXT_DEPTH = ptrh_pkg::EXT_TABLES
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  output ptrh_pkg::ptrh_status_s     status_o,
  output logic      [15:0]           act_table_o,
  output logic                       ext_ready_o
);
  import ptrh_pkg::*;

  initial begin
    if (STD_DEPTH != STD_TABLES || EXT_DEPTH != EXT_TABLES) begin
      $error("table depths must match the region sizes");
    end
  end

  typedef enum logic [1:0] {S_IDLE, S_XFER, S_RECALC, S_EXTSTART} ptrh_st_e;

  ptrh_st_e     st_q;
  logic [7:0]   axis_q;
  logic [15:0]  table_q;
  logic [15:0]  count_q;
  logic         dir_q;
  logic         ext_use_q;
  logic [15:0]  rc_table_q;
  logic [15:0]  rc_count_q;
  logic         rc_req_q;
  logic [15:0]  rec_q [REC_WORDS];
  logic [15:0]  std_mem_q [STD_TABLES][REC_WORDS];
  logic [15:0]  std_act_q [STD_TABLES][REC_WORDS];
  logic [15:0]  ext_mem_q [EXT_TABLES][REC_WORDS];
  logic [15:0]  cur_q;
  logic [15:0]  left_q;
  logic [3:0]   word_q;
  logic [7:0]   wait_q;
  logic [15:0]  start_tbl_q;
  logic [15:0]  chain_q;
  logic [15:0]  lat_q;
  logic [15:0]  act_q;
  logic         xfer_done_q;
  logic         recalc_done_q;
  logic         err_q;
  logic         ext_start_q;

  wire logic        acc_w;
  wire logic        wr_w;
  wire logic        rd_w;
  wire logic        rec_hit_w;
  wire logic [3:0]  rec_idx_w;
  wire logic        std_ok_w;
  wire logic        ext_ok_w;
  wire logic        rc_ok_w;
  wire logic        axis_ok_w;
  wire logic        is_ext_w;
  wire logic        span_ok_w;
  wire logic        req_w;
  wire logic        start_w;
  wire logic        rc_go_w;
  wire logic [9:0]  std_idx_w;
  wire logic [6:0]  ext_idx_w;
  wire logic        mapped_w;
  logic      [31:0] rdata_w;

  assign acc_w     = psel && penable;
  assign wr_w      = acc_w && pwrite;
  assign rd_w      = acc_w && !pwrite;
  assign rec_hit_w = (paddr >= OFS_REC_BASE) &&
                     (paddr < OFS_REC_BASE + 12'(4 * REC_WORDS)) &&
                     (paddr[1:0] == 2'b00);
  assign rec_idx_w = 4'((paddr - OFS_REC_BASE) >> 2);            // RQ2

  ptrh_range_chk u_std (.first(table_q), .count(count_q),
    .lo(STD_FIRST), .hi(STD_LAST), .ok(std_ok_w));               // RQ9
  ptrh_range_chk u_ext (.first(table_q), .count(count_q),
    .lo(EXT_FIRST), .hi(EXT_LAST), .ok(ext_ok_w));               // RQ10

  assign rc_ok_w   = (rc_table_q >= STD_FIRST) &&
                     ({1'b0, rc_table_q} + {1'b0, rc_count_q} <=
                      {1'b0, STD_LAST} + 17'd1);
  // RQ16
  assign axis_ok_w = (axis_q >= AXIS_REAL_LO && axis_q <= AXIS_REAL_HI) ||
                     (axis_q >= AXIS_VIRT_LO && axis_q <= AXIS_VIRT_HI);
  assign is_ext_w  = table_q >= EXT_FIRST;
  // RQ15 RQ17
  assign span_ok_w = axis_ok_w && (is_ext_w ? (ext_use_q && ext_ok_w)
                                            : std_ok_w);
  assign req_w     = wr_w && paddr == OFS_CTRL && pwdata[CTRL_REQ_BIT];
  assign start_w   = wr_w && paddr == OFS_CTRL && pwdata[CTRL_START_BIT];
  assign rc_go_w   = rc_req_q && !recalc_done_q && rc_count_q != 16'h0000;
  assign std_idx_w = 10'(cur_q - STD_FIRST);
  assign ext_idx_w = 7'(cur_q - EXT_FIRST);

  assign mapped_w = rec_hit_w || paddr == OFS_AXIS || paddr == OFS_TABLE ||
                    paddr == OFS_COUNT || paddr == OFS_CTRL ||
                    paddr == OFS_STATUS || paddr == OFS_EXT_USE ||
                    paddr == OFS_RC_TABLE || paddr == OFS_RC_COUNT ||
                    paddr == OFS_RC_CTRL || paddr == OFS_ACT_TABLE ||
                    paddr == OFS_LATENCY;

  always_comb begin
    rdata_w = RST_WORD;
    if (rec_hit_w) begin
      rdata_w = {16'h0000, rec_q[rec_idx_w]};
    end else begin
      unique case (paddr)
        OFS_AXIS:      rdata_w = {24'h00_0000, axis_q};
        OFS_TABLE:     rdata_w = {16'h0000, table_q};
        OFS_COUNT:     rdata_w = {16'h0000, count_q};
        OFS_CTRL:      rdata_w = {30'h0000_0000, dir_q, 1'b0};
        OFS_STATUS:    rdata_w = {27'h000_0000, status_o};
        OFS_EXT_USE:   rdata_w = {31'h0000_0000, ext_use_q};
        OFS_RC_TABLE:  rdata_w = {16'h0000, rc_table_q};
        OFS_RC_COUNT:  rdata_w = {16'h0000, rc_count_q};
        OFS_RC_CTRL:   rdata_w = {31'h0000_0000, rc_req_q};
        OFS_ACT_TABLE: rdata_w = {16'h0000, act_q};
        OFS_LATENCY:   rdata_w = {16'h0000, lat_q};
        default:       rdata_w = RST_WORD;
      endcase
    end
  end

  assign pready   = 1'b1;
  assign pslverr  = acc_w && !mapped_w;
  assign status_o = '{busy: st_q != S_IDLE, xfer_done: xfer_done_q,
                      recalc_done: recalc_done_q, error: err_q,
                      ext_started: ext_start_q};
  assign act_table_o = act_q;
  assign ext_ready_o = ext_start_q;

  // loaded in the setup phase so read data stands at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= RST_WORD;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_w;
    end
  end

  // software-written control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      axis_q     <= 8'h00;
      table_q    <= 16'h0000;
      count_q    <= 16'h0000;
      dir_q      <= 1'b0;
      ext_use_q  <= 1'b0;
      rc_table_q <= 16'h0000;
      rc_count_q <= 16'h0000;
      rc_req_q   <= 1'b0;
    end else if (wr_w) begin
      if (paddr == OFS_AXIS)     axis_q     <= pwdata[7:0];
      if (paddr == OFS_TABLE)    table_q    <= pwdata[15:0];
      if (paddr == OFS_COUNT)    count_q    <= pwdata[15:0];
      if (paddr == OFS_CTRL)     dir_q      <= pwdata[CTRL_DIR_BIT];
      if (paddr == OFS_EXT_USE)  ext_use_q  <= pwdata[0];       // RQ15
      if (paddr == OFS_RC_TABLE) rc_table_q <= pwdata[15:0];
      if (paddr == OFS_RC_COUNT) rc_count_q <= pwdata[15:0];
      if (paddr == OFS_RC_CTRL)  rc_req_q   <= pwdata[RC_REQ_BIT];
    end
  end

  // engine: transfers, recalculation, extended start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q          <= S_IDLE;
      cur_q         <= 16'h0000;
      left_q        <= 16'h0000;
      word_q        <= 4'h0;
      wait_q        <= 8'h00;
      start_tbl_q   <= 16'h0000;
      chain_q       <= 16'h0000;
      lat_q         <= 16'h0000;
      act_q         <= 16'h0000;
      xfer_done_q   <= 1'b0;
      recalc_done_q <= 1'b0;
      err_q         <= 1'b0;
      ext_start_q   <= 1'b0;
      for (int i = 0; i < REC_WORDS; i++) rec_q[i] <= 16'h0000;
      for (int t = 0; t < STD_TABLES; t++) begin
        for (int w = 0; w < REC_WORDS; w++) begin
          std_mem_q[t][w] <= 16'h0000;
          std_act_q[t][w] <= 16'h0000;
        end
      end
      for (int t = 0; t < EXT_TABLES; t++) begin
        for (int w = 0; w < REC_WORDS; w++) ext_mem_q[t][w] <= 16'h0000;
      end
    end else begin
      if (wr_w && rec_hit_w && st_q == S_IDLE) begin
        rec_q[rec_idx_w] <= pwdata[15:0];
      end
      // recalc done flag drops when the host lifts its recalc request
      if (!rc_req_q) recalc_done_q <= 1'b0;                         // RQ18
      unique case (st_q)
        S_IDLE: begin
          if (req_w) begin                                          // RQ5
            xfer_done_q <= 1'b0;
            if (span_ok_w) begin
              err_q  <= 1'b0;
              cur_q  <= table_q;
              left_q <= count_q;
              word_q <= 4'h0;
              st_q   <= S_XFER;
            end else begin
              err_q  <= 1'b1;                                       // RQ17
            end
          end else if (start_w) begin
            ext_start_q <= 1'b0;
            if (ext_use_q && ext_ok_w && axis_ok_w) begin
              err_q       <= 1'b0;
              start_tbl_q <= table_q;
              chain_q     <= count_q;
              // longer chains of pass/continuance points wait longer
              lat_q       <= 16'(count_q * RECALC_CYCLES);          // RQ14
              wait_q      <= RECALC_CYCLES;
              st_q        <= S_EXTSTART;                            // RQ13
            end else begin
              err_q <= 1'b1;
            end
          end else if (rc_go_w) begin
            if (rc_ok_w) begin
              cur_q  <= rc_table_q;
              left_q <= rc_count_q;
              word_q <= 4'h0;
              st_q   <= S_RECALC;
            end else begin
              err_q         <= 1'b1;
              recalc_done_q <= 1'b1;
            end
          end
        end
        S_XFER: begin
          // one word a cycle, records of fourteen words
          if (is_ext_w) begin
            if (dir_q == PTRH_DIR_WRITE) begin
              ext_mem_q[ext_idx_w][word_q] <= rec_q[word_q];        // RQ12
            end else begin
              rec_q[word_q] <= ext_mem_q[ext_idx_w][word_q];
            end
          end else begin
            if (dir_q == PTRH_DIR_WRITE) begin
              std_mem_q[std_idx_w][word_q] <= rec_q[word_q];        // RQ11
            end else begin
              rec_q[word_q] <= std_mem_q[std_idx_w][word_q];
            end
          end
          if (word_q == 4'(REC_WORDS - 1)) begin                    // RQ2
            word_q <= 4'h0;
            cur_q  <= cur_q + 16'h0001;
            left_q <= left_q - 16'h0001;
            if (left_q == 16'h0001) begin
              xfer_done_q <= 1'b1;                                  // RQ18
              st_q        <= S_IDLE;
            end
          end else begin
            word_q <= word_q + 4'h1;
          end
        end
        S_RECALC: begin
          // staged standard data becomes active only here
          std_act_q[std_idx_w][word_q] <= std_mem_q[std_idx_w][word_q]; // RQ11
          if (word_q == 4'(REC_WORDS - 1)) begin
            word_q <= 4'h0;
            cur_q  <= cur_q + 16'h0001;
            left_q <= left_q - 16'h0001;
            if (left_q == 16'h0001) begin
              recalc_done_q <= 1'b1;                                // RQ18
              st_q          <= S_IDLE;
            end
          end else begin
            word_q <= word_q + 4'h1;
          end
        end
        S_EXTSTART: begin
          if (wait_q == 8'h01) begin
            chain_q <= chain_q - 16'h0001;
            wait_q  <= RECALC_CYCLES;
            if (chain_q == 16'h0001) begin
              act_q       <= start_tbl_q;
              ext_start_q <= 1'b1;                                  // RQ13
              st_q        <= S_IDLE;
            end
          end else begin
            wait_q <= wait_q - 8'h01;
          end
        end
      endcase
    end
  end

  xfer_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == S_IDLE && req_w && !span_ok_w) |=> err_q && st_q == S_IDLE)
    else $error("bad span not refused"); // RQ17
  ext_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == S_IDLE && req_w && is_ext_w && !ext_use_q) |=> st_q == S_IDLE)
    else $error("extended used while disabled"); // RQ15
  axis_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == S_IDLE && req_w && axis_q == 8'h61) |=> err_q)
    else $error("axis 97 accepted"); // RQ16
  rec_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == S_IDLE && req_w && span_ok_w && count_q == 16'h0001)
    |=> st_q == S_XFER ##13 st_q == S_XFER ##1 xfer_done_q)
    else $error("record not fourteen words"); // RQ2
  xfer_go_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == S_IDLE && req_w && span_ok_w) |=> st_q == S_XFER)
    else $error("transfer not started"); // RQ5
  rc_done_a: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(recalc_done_q) |-> $past(st_q) != S_XFER)
    else $error("recalc done from transfer"); // RQ18
  std_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_q != S_RECALC |=> $stable(std_act_q[0][0]))
    else $error("active table changed without recalc"); // RQ11
  ext_lat_a: assert property (@(posedge pclk) disable iff (!presetn)
    (st_q == S_IDLE && start_w && ext_use_q && ext_ok_w && axis_ok_w &&
     count_q == 16'h0001) |=> !ext_start_q ##15 !ext_start_q ##1 ext_start_q)
    else $error("extended start delay wrong"); // RQ13 RQ14
  range_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_q == S_XFER |-> (cur_q >= STD_FIRST && cur_q <= STD_LAST) ||
                       (cur_q >= EXT_FIRST && cur_q <= EXT_LAST))
    else $error("table outside regions"); // RQ9 RQ10
endmodule

//--- design/ptrh_range_chk.sv
/*
  ptrh_range_chk: checks that a table span lies inside one region.
  assumes: first and count come from registers on the same clock.
*/
`timescale 1ns/100ps
module ptrh_range_chk (
  input  wire logic [15:0] first,
  input  wire logic [15:0] count,
  input  wire logic [15:0] lo,
  input  wire logic [15:0] hi,
  output logic             ok
);
  wire logic [16:0] last_w;

  assign last_w = {1'b0, first} + {1'b0, count} - 17'd1;
  assign ok = (count != 16'h0000) && (first >= lo) &&
              (last_w <= {1'b0, hi});
endmodule

//--- include/ptrh_pkg.sv
/*
  ptrh_pkg: constants, types and register map of the positioning table
  rewrite handshake block.
  assumes: apb slave with 32-bit data, registers on aligned words.
*/
package ptrh_pkg;

  localparam int unsigned REC_WORDS     = 14;
  localparam int unsigned STD_TABLES    = 1000;
  localparam int unsigned EXT_TABLES    = 100;
  localparam logic [15:0] STD_FIRST     = 16'h0001;
  localparam logic [15:0] STD_LAST      = 16'h03E8;
  localparam logic [15:0] EXT_FIRST     = 16'h2711;
  localparam logic [15:0] EXT_LAST      = 16'h2774;
  localparam logic [7:0]  AXIS_REAL_LO  = 8'h01;
  localparam logic [7:0]  AXIS_REAL_HI  = 8'h40;
  localparam logic [7:0]  AXIS_VIRT_LO  = 8'h41;
  localparam logic [7:0]  AXIS_VIRT_HI  = 8'h60;

  // byte offsets of the register map
  localparam logic [11:0] OFS_AXIS      = 12'h000;
  localparam logic [11:0] OFS_TABLE     = 12'h004;
  localparam logic [11:0] OFS_COUNT     = 12'h008;
  localparam logic [11:0] OFS_CTRL      = 12'h00C;
  localparam logic [11:0] OFS_STATUS    = 12'h010;
  localparam logic [11:0] OFS_EXT_USE   = 12'h014;
  localparam logic [11:0] OFS_RC_TABLE  = 12'h018;
  localparam logic [11:0] OFS_RC_COUNT  = 12'h01C;
  localparam logic [11:0] OFS_RC_CTRL   = 12'h020;
  localparam logic [11:0] OFS_ACT_TABLE = 12'h024;
  localparam logic [11:0] OFS_LATENCY   = 12'h028;
  localparam logic [11:0] OFS_REC_BASE  = 12'h040;

  localparam int unsigned CTRL_REQ_BIT  = 0;
  localparam int unsigned CTRL_DIR_BIT  = 1;
  localparam int unsigned CTRL_START_BIT = 2;
  localparam int unsigned RC_REQ_BIT    = 0;

  localparam logic [31:0] RST_WORD      = 32'h0000_0000;
  // cycles per record moved, cycles of internal recalculation per table
  localparam logic [7:0]  XFER_CYCLES   = 8'h0E;
  localparam logic [7:0]  RECALC_CYCLES = 8'h10;

  typedef enum logic {PTRH_DIR_READ, PTRH_DIR_WRITE} ptrh_dir_e;

  typedef struct packed {
    logic        busy;
    logic        xfer_done;
    logic        recalc_done;
    logic        error;
    logic        ext_started;
  } ptrh_status_s;

endpackage

//--- testbench/ptrh_core_test.sv
/*
  ptrh_core_test: self-checking bench for the table rewrite block.
  assumes: host model drives apb; expectations from package constants.
*/
`timescale 1ns/100ps
module ptrh_core_test;
  import ptrh_pkg::*;
  logic         pclk;
  logic         presetn;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [11:0]  paddr;
  logic [31:0]  pwdata;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  ptrh_status_s status_o;
  logic [15:0]  act_table_o;
  logic         ext_ready_o;
  int           err_count;
  int           samples_checked;
  logic [31:0]  rd;
  int           n1;
  int           n3;
  // axis, first table, count, extended usage, expected error
  logic [7:0]   t_ax [0:10] = '{8'h00, 8'h61, 8'h60, 8'h41, 8'h40,
                                8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01};
  logic [15:0]  t_fi [0:10] = '{16'h0001, 16'h0001, 16'h0001, 16'h03E8,
                                16'h03E8, 16'h0000, 16'h2711, 16'h2774,
                                16'h2774, 16'h2710, 16'h03E9};
  logic [15:0]  t_cn [0:10] = '{16'h0001, 16'h0001, 16'h0001, 16'h0001,
                                16'h0002, 16'h0001, 16'h0001, 16'h0001,
                                16'h0002, 16'h0001, 16'h0001};
  logic         t_ex [0:10] = '{0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 1};
  logic         t_er [0:10] = '{1, 1, 0, 0, 1, 1, 1, 0, 1, 1, 1};

  ptrh_host_model u_host (.pclk(pclk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata));

  ptrh_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .status_o(status_o), .act_table_o(act_table_o),
    .ext_ready_o(ext_ready_o));

  initial pclk = 1'b0;
  always #50 pclk = ~pclk;

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic span(input logic [7:0] ax, input logic [15:0] fi,
                      input logic [15:0] cn);
    u_host.wr_reg(OFS_AXIS, {24'h00_0000, ax});
    u_host.wr_reg(OFS_TABLE, {16'h0000, fi});
    u_host.wr_reg(OFS_COUNT, {16'h0000, cn});
  endtask

  // busy rises an edge after the request, so let it land first
  task automatic wait_idle;
    int n;
    n = 0;
    repeat (2) @(posedge pclk);
    while (status_o.busy !== 1'b0 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    #1;
  endtask

  task automatic ext_start(input logic [15:0] cn, output int n);
    span(8'h01, EXT_FIRST, cn);
    u_host.wr_reg(OFS_CTRL, 32'h0000_0004);
    n = 0;
    while (ext_ready_o === 1'b1 && n < 4) begin
      @(posedge pclk);
      n++;
    end
    while (ext_ready_o !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    check("ext_delay_ok", 32'(n >= 16 * cn - 1 && n <= 16 * cn + 3), 1);
    check("act_table", {16'h0000, act_table_o}, {16'h0000, EXT_FIRST});
    // estimate is latched by the start request, so read it afterwards
    u_host.rd_reg(OFS_LATENCY, rd);
    check("latency_est", rd, 32'(16 * cn));
  endtask

  initial begin
    presetn = 1'b0;
    err_count = 0;
    samples_checked = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    check("status_rst", 32'(status_o), 32'h0000_0000);
    check("ext_ready_rst", 32'(ext_ready_o), 32'h0000_0000);
    u_host.rd_reg(OFS_EXT_USE, rd);
    check("ext_use_rst", rd, 32'h0000_0000);
    u_host.rd_reg(12'h030, rd);
    check("unmapped_err", 32'(u_host.last_err), 32'h0000_0001);
    check("unmapped_data", rd, 32'h0000_0000);
    for (int i = 0; i < REC_WORDS; i++)
      u_host.wr_reg(OFS_REC_BASE + 12'(4 * i), {16'hFFFF, 16'(16'hA500 + i)});
    span(8'h01, STD_FIRST, 16'h0001);
    u_host.wr_reg(OFS_CTRL, 32'h0000_0003);
    wait_idle();
    check("std_write", 32'(status_o) & 32'h0000_000A, 32'h0000_0008);
    for (int i = 0; i < REC_WORDS; i++)
      u_host.wr_reg(OFS_REC_BASE + 12'(4 * i), 32'h0000_0000);
    u_host.wr_reg(OFS_CTRL, 32'h0000_0001);
    wait_idle();
    for (int i = 0; i < REC_WORDS; i++) begin
      u_host.rd_reg(OFS_REC_BASE + 12'(4 * i), rd);
      check("rec_word", rd, {16'h0000, 16'(16'hA500 + i)});
    end
    u_host.wr_reg(OFS_RC_TABLE, 32'h0000_0001);
    u_host.wr_reg(OFS_RC_COUNT, 32'h0000_0001);
    u_host.wr_reg(OFS_RC_CTRL, 32'h0000_0001);
    n1 = 0;
    while (status_o.recalc_done !== 1'b1 && n1 < 100) begin
      @(posedge pclk);
      n1++;
    end
    check("recalc_time", 32'(n1 <= 20), 32'h0000_0001);
    u_host.wr_reg(OFS_RC_CTRL, 32'h0000_0000);
    @(posedge pclk);
    #1;
    check("recalc_clear", 32'(status_o.recalc_done), 32'h0000_0000);
    u_host.wr_reg(OFS_RC_COUNT, 32'h0000_0000);
    u_host.rd_reg(OFS_RC_COUNT, rd);
    check("recalc_count", rd, 32'h0000_0000);
    for (int i = 0; i < 11; i++) begin
      u_host.wr_reg(OFS_EXT_USE, 32'(t_ex[i]));
      span(t_ax[i], t_fi[i], t_cn[i]);
      u_host.wr_reg(OFS_CTRL, 32'h0000_0003);
      wait_idle();
      check("range_result", 32'(status_o) & 32'h0000_000A,
            t_er[i] ? 32'h0000_0002 : 32'h0000_0008);
    end
    u_host.wr_reg(OFS_EXT_USE, 32'h0000_0001);
    ext_start(16'h0003, n3);
    ext_start(16'h0001, n1);
    check("chain_longer", 32'(n3 > n1), 32'h0000_0001);
    check("apb_hang", 32'(u_host.hang), 32'h0000_0000);
    end_sim();
  end

  initial begin
    #(100 * 20000);
    err_count++;
    end_sim();
  end
endmodule

//--- testbench/ptrh_host_model.sv
/*
  ptrh_host_model: apb master standing in for the host program that
  rewrites positioning tables; the test calls its tasks by path.
  assumes: one apb slave on pclk, answer within 64 access-phase edges.
*/
`timescale 1ns/100ps
module ptrh_host_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata
);
  logic last_err;
  int   hang;

  initial begin
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 12'h000;
    pwdata   = 32'h0000_0000;
    last_err = 1'b0;
    hang     = 0;
  end

  // request held until pready is seen at an edge or 64 access-phase edges pass, released only then
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (n >= 64) hang++;
    // answer taken at the edge where pready is seen high
    last_err = pslverr;
    rd       = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] unused;
    xfer(1'b1, a, d, unused);
  endtask

  task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
    xfer(1'b0, a, 32'h0000_0000, d);
  endtask
endmodule
